// [hw/mhp_dev.sv]
// Purpose: device end of the multi-mode host bus port
// Assumes: pins synchronous to CLK_SYS, shift clock far slower than CLK_SYS
// Notes:   register file lives outside; read data must answer in the REG_RD cycle
`timescale 1ns/1ps
// Overview of operation
// - separate-address modes use seven address pins
// - separate-address modes use shared pins as data
// - multiplexed mode shares pins for address, data
// - multiplexed address captured at latch falling edge
// - write strobe low writes, read low reads
// - direction mode: write line low write, high read
// - host supplies shift clock on latch pin
// - serial input sampled on rising shift edge
// - edge select high falling, low rising output
// - serial mode grounds unused address, data, strobes
// - multiplexed mode grounds all seven address pins
// - separate modes ground latch; eprom grounds strobes
// - mode field loaded from mode pins after reset
// - chip select low for whole access; in mux mode it falls only after the address latch
// - strobe modes: ready high when done, low for waits
module mhp_dev #(
  parameter int AW = mhp_pkg::ADDR_W,
  parameter int DW = mhp_pkg::DATA_W
) (
  input wire logic CLK_SYS,            // system clock
  input wire logic RST,                // async reset, active high
  input wire logic CE,                 // clock enable, freezes state when low
  mhp_bus_if.dev_mp BUS,               // host pins
  input wire logic [2:0] HOST_MODE_PINS, // mode straps
  input wire logic MODE_WR,            // software rewrite of the mode field
  input wire logic [2:0] MODE_WDATA,   // new mode field value
  output logic [2:0] HOST_MODE_SEL,    // current mode field
  output logic [2:0] MODE_PIN_STS,     // live copy of the mode pins
  output logic REG_RD,                 // read pulse to register file
  output logic REG_WR,                 // write pulse to register file
  output logic [AW-1:0] REG_ADDR,      // register address
  output logic [DW-1:0] REG_WDATA,     // write data
  input wire logic [DW-1:0] REG_RDATA  // read data, valid in REG_RD cycle
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_FETCH = 4'h2,
    D_RHOLD = 4'h4,
    D_WACT = 4'h8
  } mhp_dstate_t;

  mhp_dstate_t state_r;
  logic [2:0] mode_r;
  logic loaded_r;
  logic rd_req, wr_req, rd_q_r, wr_q_r, ale_q_r, cs_q_r;
  logic cs_act, ser, mux, latch_fall, sclk_rise, sclk_fall, upd_edge;
  logic [AW-1:0] lat_addr_r, addr_src;
  logic [DW-1:0] dout_r;
  logic [15:0] sh_r;
  logic [4:0] cnt_r;
  logic sdo_r, rd_r, wr_r;
  logic [AW-1:0] raddr_r;
  logic [DW-1:0] wdata_r;

  // true for the modes with a dedicated address bus
  function automatic logic sep_addr(input logic [2:0] m);
    sep_addr = (m == mhp_pkg::MODE_EPROM) || (m == mhp_pkg::MODE_RWSTB) ||
               (m == mhp_pkg::MODE_DIRSTB);
  endfunction

  // ------------------------------------------------------------
  // mode field
  // ------------------------------------------------------------
  // straps are caught on the first enabled edge after release, since an
  // async reset may only load a constant
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      mode_r <= mhp_pkg::MODE_RST;
      loaded_r <= 1'b0;
    end else if (CE) begin
      if (!loaded_r) begin
        mode_r <= HOST_MODE_PINS;
        loaded_r <= 1'b1;
      end else if (MODE_WR) begin
        mode_r <= MODE_WDATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      MODE_PIN_STS <= 3'h0;
    end else if (CE) begin
      MODE_PIN_STS <= HOST_MODE_PINS;
    end
  end

  assign HOST_MODE_SEL = mode_r;
  assign ser = (mode_r == mhp_pkg::MODE_SERIAL);
  assign mux = (mode_r == mhp_pkg::MODE_MUX);
  assign cs_act = !BUS.cs_n;

  // ------------------------------------------------------------
  // strobe decode
  // ------------------------------------------------------------
  // eprom reads on chip select alone; strobe pins are grounded there
  always_comb begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    case (mode_r)
      mhp_pkg::MODE_EPROM: rd_req = cs_act;
      mhp_pkg::MODE_MUX, mhp_pkg::MODE_RWSTB: begin
        rd_req = cs_act && !BUS.rd_n;
        wr_req = cs_act && !BUS.wr_n;
      end
      mhp_pkg::MODE_DIRSTB: begin
        rd_req = cs_act && BUS.wr_n;
        wr_req = cs_act && !BUS.wr_n;
      end
      default: begin
        rd_req = 1'b0;
        wr_req = 1'b0;
      end
    endcase
  end

  // previous pin levels for edge detection
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
      ale_q_r <= 1'b0;
      cs_q_r <= 1'b0;
    end else if (CE) begin
      rd_q_r <= rd_req;
      wr_q_r <= wr_req;
      ale_q_r <= BUS.ale;
      cs_q_r <= cs_act;
    end
  end

  assign latch_fall = mux && ale_q_r && !BUS.ale;
  assign sclk_rise = ser && cs_act && BUS.ale && !ale_q_r;
  assign sclk_fall = ser && cs_act && !BUS.ale && ale_q_r;
  assign upd_edge = BUS.addr[1] ? sclk_fall : sclk_rise;

  // multiplexed address latch
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lat_addr_r <= '0;
    end else if (CE && latch_fall) begin
      lat_addr_r <= BUS.ad[AW-1:0];
    end
  end

  assign addr_src = sep_addr(mode_r) ? BUS.addr : lat_addr_r;

  // ------------------------------------------------------------
  // serial input shifter
  // ------------------------------------------------------------
  // chip select going low opens a frame and clears the bit count
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sh_r <= '0;
      cnt_r <= '0;
    end else if (CE) begin
      if (cs_act && !cs_q_r) begin
        cnt_r <= '0;
      end else if (sclk_rise) begin
        sh_r <= {sh_r[14:0], BUS.addr[0]};
        cnt_r <= cnt_r + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // access sequencer, parallel and serial
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r <= D_IDLE;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      raddr_r <= '0;
      wdata_r <= '0;
      dout_r <= '0;
      sdo_r <= 1'b0;
    end else if (CE) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      if (ser) begin
        if (!cs_act) begin
          state_r <= D_IDLE;
          sdo_r <= 1'b0;
        end else if (sclk_rise && cnt_r == mhp_pkg::SER_HDR_LAST &&
                     sh_r[6] == mhp_pkg::SER_RW_READ) begin
          raddr_r <= {sh_r[5:0], BUS.addr[0]};
          rd_r <= 1'b1;
          state_r <= D_FETCH;
        end else if (sclk_rise && cnt_r == mhp_pkg::SER_FRM_LAST &&
                     sh_r[14] != mhp_pkg::SER_RW_READ) begin
          raddr_r <= sh_r[13:7];
          wdata_r <= {sh_r[6:0], BUS.addr[0]};
          wr_r <= 1'b1;
        end else if (state_r == D_FETCH) begin
          dout_r <= REG_RDATA;
          state_r <= D_RHOLD;
        end else if (state_r == D_RHOLD && upd_edge && cnt_r >= mhp_pkg::SER_DATA_FIRST) begin
          sdo_r <= dout_r[DW-1];
          dout_r <= {dout_r[DW-2:0], 1'b0};
        end
      end else begin
        case (state_r)
          D_IDLE: begin
            if (rd_req && !rd_q_r) begin
              raddr_r <= addr_src;
              rd_r <= 1'b1;
              state_r <= D_FETCH;
            end else if (wr_req && !wr_q_r) begin
              state_r <= D_WACT;
            end
          end
          D_FETCH: begin
            dout_r <= REG_RDATA;
            state_r <= D_RHOLD;
          end
          D_RHOLD: begin
            if (!rd_req) begin
              state_r <= D_IDLE;
            end
          end
          D_WACT: begin
            // data taken while the strobe is still low, written as it ends
            if (wr_req) begin
              raddr_r <= addr_src;
              wdata_r <= BUS.ad;
            end else begin
              wr_r <= 1'b1;
              state_r <= D_IDLE;
            end
          end
          default: state_r <= D_IDLE;
        endcase
      end
    end
  end

  assign REG_RD = rd_r;
  assign REG_WR = wr_r;
  assign REG_ADDR = raddr_r;
  assign REG_WDATA = wdata_r;

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // serial drives all eight data pins: the lowest with the output bit, the rest at zero
  always_comb begin
    BUS.ad_d_oe = 1'b0;
    BUS.ad_d_o = dout_r;
    BUS.rdy = 1'b0;
    if (ser) begin
      BUS.ad_d_oe = cs_act && (state_r == D_RHOLD);
      BUS.ad_d_o = {7'h00, sdo_r};
    end else begin
      BUS.ad_d_oe = rd_req && (state_r == D_RHOLD);
    end
    case (mode_r)
      mhp_pkg::MODE_MUX, mhp_pkg::MODE_RWSTB:
        BUS.rdy = !(rd_req && state_r != D_RHOLD);
      // acknowledge is active low in the direction-line mode
      mhp_pkg::MODE_DIRSTB:
        BUS.rdy = !(state_r == D_RHOLD || state_r == D_WACT);
      default: BUS.rdy = 1'b0;
    endcase
  end
endmodule

// [hw/mhp_pkg.sv]
// Purpose: shared constants for the multi-mode host bus port (both ends)
// Assumes: all pins are synchronous to the 125 MHz system clock
// Notes:   serial frame is rw flag, 7 address bits, 8 data bits, msb first
package mhp_pkg;
  // ------------------------------------------------------------
  // bus shape
  // ------------------------------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int MODE_W = 3;

  // ------------------------------------------------------------
  // host mode codes, as strapped on the mode pins
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_NONE   = 3'h0,
    MODE_EPROM  = 3'h1,
    MODE_MUX    = 3'h2,
    MODE_RWSTB  = 3'h3,
    MODE_DIRSTB = 3'h4,
    MODE_SERIAL = 3'h5
  } mhp_mode_t;
  localparam logic [2:0] MODE_RST = 3'h0;

  // ------------------------------------------------------------
  // serial frame layout
  // ------------------------------------------------------------
  localparam int SER_FRAME_BITS = 16;
  localparam logic [4:0] SER_HDR_LAST = 5'h07;   // rise that ends rw + address
  localparam logic [4:0] SER_FRM_LAST = 5'h0F;   // rise that ends the data byte
  localparam logic [4:0] SER_DATA_FIRST = 5'h08;
  localparam logic SER_RW_READ = 1'b1;

  // ------------------------------------------------------------
  // timing, 8 ns clock
  // ------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int HOST_PHASE_NS = 16;             // least setup / hold per strobe phase
  localparam int HOST_PHASE_CYC = (HOST_PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_HALF_NS = 40;              // least shift clock half period
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int EPROM_WAIT_NS = 48;             // fixed read wait, no ready in this mode
  localparam int EPROM_WAIT_CYC = (EPROM_WAIT_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [hw/mhp_bus_if.sv]
// Purpose: pin bundle joining the host end and the device end
// Assumes: pulled-down shared data pins read as zero when nobody drives
// Notes:   the resolved data bus is worked out here from both enables
`timescale 1ns/1ps
interface mhp_bus_if;
  logic cs_n;
  logic [6:0] addr;     // addr[0] serial_in_line, addr[1] shift_edge_select
  logic wr_n;
  logic rd_n;
  logic ale;            // shift clock in serial mode
  logic rdy;
  logic [7:0] ad_h_o;
  logic ad_h_oe;
  logic [7:0] ad_d_o;   // ad_d_o[0] is serial_out_line in serial mode
  logic ad_d_oe;
  logic [7:0] ad;

  // device wins if both drive, which only a broken host could cause
  assign ad = ad_d_oe ? ad_d_o : (ad_h_oe ? ad_h_o : 8'h00);

  modport dev_mp (input cs_n, addr, wr_n, rd_n, ale, ad, output rdy, ad_d_o, ad_d_oe);
  modport host_mp (output cs_n, addr, wr_n, rd_n, ale, ad_h_o, ad_h_oe, input rdy, ad);
endinterface

// [hw/mhp_host.sv]
// Purpose: host end of the multi-mode host bus port, one access per command
// Assumes: the device on the far side answers within the ready protocol
// Notes:   serial frames run with edge select high, sampling output at the end of each high half
`timescale 1ns/1ps
module mhp_host #(
  parameter int AW = mhp_pkg::ADDR_W,
  parameter int DW = mhp_pkg::DATA_W
) (
  input wire logic CLK_SYS,            // system clock
  input wire logic RST,                // async reset, active high
  input wire logic CE,                 // clock enable, freezes state when low
  mhp_bus_if.host_mp BUS,              // device pins
  input wire logic [2:0] MODE,         // bus mode to speak
  input wire logic CMD_VALID,          // access request
  output logic CMD_READY,              // idle, request taken when both high
  input wire logic CMD_WRITE,          // 1 write, 0 read
  input wire logic [AW-1:0] CMD_ADDR,  // register address
  input wire logic [DW-1:0] CMD_WDATA, // write data
  output logic RSP_VALID,              // one-cycle pulse, access finished
  output logic [DW-1:0] RSP_RDATA      // read data
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_ALE = 7'h02,
    H_LATCH = 7'h04,
    H_STRB = 7'h08,
    H_WAIT = 7'h10,
    H_SER = 7'h20,
    H_END = 7'h40
  } mhp_hstate_t;

  mhp_hstate_t state_r;
  logic [2:0] mode_r;
  logic wr_r, sclk_r, done;
  logic [AW-1:0] addr_r;
  logic [DW-1:0] wdata_r;
  logic [15:0] frame_r;
  logic [4:0] bit_r;
  logic [3:0] tmr_r;

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  // completion test per mode; eprom has no ready so a fixed wait is used
  always_comb begin
    case (mode_r)
      mhp_pkg::MODE_MUX, mhp_pkg::MODE_RWSTB: done = BUS.rdy;
      mhp_pkg::MODE_DIRSTB: done = !BUS.rdy;
      default: done = (tmr_r >= 4'(mhp_pkg::EPROM_WAIT_CYC));
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r <= H_IDLE;
      mode_r <= mhp_pkg::MODE_RST;
      wr_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      frame_r <= '0;
      bit_r <= '0;
      tmr_r <= '0;
      sclk_r <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= '0;
    end else if (CE) begin
      RSP_VALID <= 1'b0;
      tmr_r <= tmr_r + 4'h1;
      case (state_r)
        H_IDLE: begin
          tmr_r <= '0;
          if (CMD_VALID) begin
            mode_r <= MODE;
            wr_r <= CMD_WRITE;
            addr_r <= CMD_ADDR;
            wdata_r <= CMD_WDATA;
            frame_r <= {!CMD_WRITE, CMD_ADDR, CMD_WDATA};
            bit_r <= '0;
            sclk_r <= 1'b0;
            if (MODE == mhp_pkg::MODE_SERIAL) state_r <= H_SER;
            else if (MODE == mhp_pkg::MODE_MUX) state_r <= H_ALE;
            else state_r <= H_STRB;
          end
        end
        H_ALE: if (tmr_r == 4'(mhp_pkg::HOST_PHASE_CYC - 1)) begin
          tmr_r <= '0;
          state_r <= H_LATCH;
        end
        H_LATCH: if (tmr_r == 4'(mhp_pkg::HOST_PHASE_CYC - 1)) begin
          tmr_r <= '0;
          state_r <= H_STRB;
        end
        H_STRB: if (tmr_r == 4'(mhp_pkg::HOST_PHASE_CYC - 1)) begin
          state_r <= H_WAIT;
        end
        H_WAIT: if (done) begin
          if (!wr_r) RSP_RDATA <= BUS.ad;
          tmr_r <= '0;
          state_r <= H_END;
        end
        H_SER: if (tmr_r == 4'(mhp_pkg::SCLK_HALF_CYC - 1)) begin
          tmr_r <= '0;
          sclk_r <= !sclk_r;
          if (sclk_r) begin
            // end of the high half: device has sampled, take its output bit
            if (bit_r >= mhp_pkg::SER_DATA_FIRST && !wr_r) begin
              RSP_RDATA <= {RSP_RDATA[DW-2:0], BUS.ad[0]};
            end
            frame_r <= {frame_r[14:0], 1'b0};
            bit_r <= bit_r + 5'h01;
            if (bit_r == mhp_pkg::SER_FRM_LAST) state_r <= H_END;
          end
        end
        H_END: if (tmr_r == 4'(mhp_pkg::HOST_PHASE_CYC - 1)) begin
          RSP_VALID <= 1'b1;
          state_r <= H_IDLE;
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drivers
  // ------------------------------------------------------------
  // unused pins are driven low, standing in for the board ground
  always_comb begin
    BUS.cs_n = !(state_r == H_STRB || state_r == H_WAIT || state_r == H_SER);
    BUS.ale = (state_r == H_ALE) || (state_r == H_SER && sclk_r);
    BUS.addr = addr_r;
    BUS.wr_n = 1'b1;
    BUS.rd_n = 1'b1;
    BUS.ad_h_o = wdata_r;
    BUS.ad_h_oe = 1'b0;
    case (mode_r)
      mhp_pkg::MODE_EPROM: begin
        BUS.wr_n = 1'b0;
        BUS.rd_n = 1'b0;
      end
      mhp_pkg::MODE_MUX: begin
        BUS.addr = 7'h00;
        if (state_r == H_ALE || state_r == H_LATCH) begin
          BUS.ad_h_o = {1'b0, addr_r};
          BUS.ad_h_oe = 1'b1;
        end else begin
          BUS.ad_h_oe = wr_r && !BUS.cs_n;
        end
        BUS.wr_n = !(wr_r && !BUS.cs_n);
        BUS.rd_n = !(!wr_r && !BUS.cs_n);
      end
      mhp_pkg::MODE_RWSTB: begin
        BUS.ad_h_oe = wr_r && !BUS.cs_n;
        BUS.wr_n = !(wr_r && !BUS.cs_n);
        BUS.rd_n = !(!wr_r && !BUS.cs_n);
      end
      mhp_pkg::MODE_DIRSTB: begin
        BUS.ad_h_oe = wr_r && !BUS.cs_n;
        BUS.wr_n = !wr_r;
        BUS.rd_n = 1'b0;
      end
      mhp_pkg::MODE_SERIAL: begin
        BUS.addr = {5'h00, 1'b1, frame_r[15]};
        BUS.wr_n = 1'b0;
        BUS.rd_n = 1'b0;
      end
      default: begin
        BUS.addr = addr_r;
      end
    endcase
  end

  assign CMD_READY = (state_r == H_IDLE);
endmodule

// [tb/mhp_bus_props.sv]
// Purpose: pin-level checks on the bus joining the host and device ends
// Assumes: one clock domain; the mode field is taken from the device end
// Notes:   only bus pins and the mode field are watched, no internals
`timescale 1ns/1ps
module mhp_bus_props (
  input wire logic CLK_SYS, // system clock
  input wire logic RST, // async reset, active high
  input wire logic [2:0] HOST_MODE_SEL, // device mode field
  input wire logic cs_n, // chip select
  input wire logic [6:0] addr, // address pins
  input wire logic wr_n, // write strobe or direction
  input wire logic rd_n, // read strobe
  input wire logic ale, // latch strobe or shift clock
  input wire logic rdy, // ready from device
  input wire logic ad_h_oe, // host drives shared pins
  input wire logic ad_d_oe, // device drives shared pins
  input wire logic [7:0] ad_d_o, // device data
  input wire logic [7:0] ad // resolved shared pins
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // ------------------------------------------------------------
  // mode decodes
  // ------------------------------------------------------------
  wire logic is_mux = HOST_MODE_SEL == mhp_pkg::MODE_MUX;
  wire logic is_rw = HOST_MODE_SEL == mhp_pkg::MODE_RWSTB;
  wire logic is_dir = HOST_MODE_SEL == mhp_pkg::MODE_DIRSTB;
  wire logic is_ep = HOST_MODE_SEL == mhp_pkg::MODE_EPROM;
  wire logic is_ser = HOST_MODE_SEL == mhp_pkg::MODE_SERIAL;
  wire logic strb = is_mux || is_rw;
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_no_fight: assert property (!(ad_d_oe && ad_h_oe))
    else $error("both ends drive the shared pins");
  a_idle_release: assert property (cs_n [*2] |-> !ad_d_oe)
    else $error("device drives while deselected");
  a_mux_grnd: assert property (is_mux && !cs_n |-> addr == 7'h00)
    else $error("address pins not grounded in mux mode");
  a_ser_grnd: assert property (is_ser && !cs_n |->
    addr[6:2] == 5'h00 && !wr_n && !rd_n && ad[7:1] == 7'h00)
    else $error("unused pins not grounded in serial mode");
  a_sep_grnd: assert property ((is_ep || is_rw || is_dir) && !cs_n |->
    !ale && (!is_ep || (!wr_n && !rd_n)))
    else $error("latch or strobes not grounded");
  // wait states: two low samples, then ready with data on the pins
  a_read_wait: assert property (strb && !cs_n && $fell(rd_n) |->
    ##1 !rdy ##1 (rdy && ad_d_oe))
    else $error("read wait or data drive out of step");
  a_write_rdy: assert property (strb && !cs_n && !wr_n |-> rdy)
    else $error("ready low during a write");
  a_no_rdy: assert property ((is_ep || is_ser) |-> !rdy)
    else $error("ready raised in a mode without ready");
  a_dir_ack: assert property (is_dir && $fell(cs_n) && wr_n |-> ##2 !rdy)
    else $error("no acknowledge for direction-mode read");
  a_cs_hold: assert property (strb && !cs_n && !rd_n && !rdy |=> !cs_n)
    else $error("chip select released during wait");
  // with edge select high the output may move only while the clock is low
  a_ser_edge: assert property (is_ser && addr[1] && ad_d_oe && $past(ad_d_oe)
    && $changed(ad_d_o[0]) |-> !ale)
    else $error("serial output moved on the wrong edge");
  a_sclk_framed: assert property (is_ser && $rose(ale) |-> !cs_n)
    else $error("shift clock rose outside a frame");
  c_ser: cover property (is_ser && !cs_n && $rose(ale));
  c_mux_rd: cover property (is_mux && !cs_n && $fell(rd_n));
  c_dir_rd: cover property (is_dir && $fell(cs_n) && wr_n);
endmodule

// [tb/tb_top.sv]
// Purpose: joins both ends and runs each bus mode through write and read, eprom through read only
// Assumes: a small register memory stands in for the register file
// Notes:   expected values are the bytes the bench itself wrote
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h3;
  logic mode_wr = 1'b0;
  logic [2:0] mode_wdata = 3'h0;
  logic [2:0] hmode = 3'h3;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [6:0] cmd_addr = 7'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [2:0] mode_sel, pin_sts;
  logic reg_rd, reg_wr, cmd_ready, rsp_valid, ale_q;
  logic [6:0] reg_addr, last_wa, pin_addr, last_ra;
  logic [7:0] reg_wdata, rsp_rdata, last_wd, ale_ad;
  logic [7:0] mem [128];
  logic [15:0] ser_sh;
  int bad_count = 0;
  int checks = 0;

  mhp_bus_if u_mhp_bus_if ();
  mhp_host u_mhp_host (.CLK_SYS(clk), .RST(rst), .CE(1'b1), .BUS(u_mhp_bus_if),
    .MODE(hmode), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_WRITE(cmd_write),
    .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
  mhp_dev u_mhp_dev (.CLK_SYS(clk), .RST(rst), .CE(1'b1), .BUS(u_mhp_bus_if),
    .HOST_MODE_PINS(pins), .MODE_WR(mode_wr), .MODE_WDATA(mode_wdata),
    .HOST_MODE_SEL(mode_sel), .MODE_PIN_STS(pin_sts), .REG_RD(reg_rd), .REG_WR(reg_wr),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(mem[reg_addr]));
  mhp_bus_props u_mhp_bus_props (.CLK_SYS(clk), .RST(rst), .HOST_MODE_SEL(mode_sel),
    .cs_n(u_mhp_bus_if.cs_n), .addr(u_mhp_bus_if.addr), .wr_n(u_mhp_bus_if.wr_n),
    .rd_n(u_mhp_bus_if.rd_n), .ale(u_mhp_bus_if.ale), .rdy(u_mhp_bus_if.rdy),
    .ad_h_oe(u_mhp_bus_if.ad_h_oe), .ad_d_oe(u_mhp_bus_if.ad_d_oe),
    .ad_d_o(u_mhp_bus_if.ad_d_o), .ad(u_mhp_bus_if.ad));

  // ------------------------------------------------------------
  // clock, register memory and pin monitors
  // ------------------------------------------------------------
  initial begin
    forever #4 clk = ~clk;
  end
  // shift clock rises are found by edge detect, so one sample per bit
  always @(posedge clk) begin
    ale_q <= u_mhp_bus_if.ale;
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
      last_wa <= reg_addr;
      last_wd <= reg_wdata;
    end
    if (reg_rd) last_ra <= reg_addr;
    if (!u_mhp_bus_if.cs_n) pin_addr <= u_mhp_bus_if.addr;
    if (u_mhp_bus_if.ale) ale_ad <= u_mhp_bus_if.ad;
    if (u_mhp_bus_if.ale && !ale_q && !u_mhp_bus_if.cs_n)
      ser_sh <= {ser_sh[14:0], u_mhp_bus_if.addr[0]};
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic access(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (!cmd_ready && n < 400);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!rsp_valid && n < 400);
    `CHK("rsp_valid", 1'b1, rsp_valid)
    repeat (3) @(posedge clk);
  endtask

  task automatic set_mode(input logic [2:0] m);
    @(posedge clk);
    mode_wr <= 1'b1;
    mode_wdata <= m;
    hmode <= m;
    @(posedge clk);
    mode_wr <= 1'b0;
    @(posedge clk);
    `CHK("mode_sel", m, mode_sel)
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_straps;
    `CHK("mode_sel", 3'h3, mode_sel)
    pins <= 3'h5;
    repeat (3) @(posedge clk);
    `CHK("mode_sel kept", 3'h3, mode_sel)
    `CHK("pin_sts", 3'h5, pin_sts)
    $display("test straps done");
  endtask

  task automatic t_rwstb;
    set_mode(mhp_pkg::MODE_RWSTB);
    access(1'b1, 7'h7F, 8'hA5);
    `CHK("wr addr", 7'h7F, last_wa)
    `CHK("wr data", 8'hA5, last_wd)
    `CHK("addr pins", 7'h7F, pin_addr)
    access(1'b1, 7'h00, 8'h5A);
    access(1'b0, 7'h7F, 8'h00);
    `CHK("rd data", 8'hA5, rsp_rdata)
    `CHK("rd addr", 7'h7F, last_ra)
    $display("test rwstb done");
  endtask

  task automatic t_dir;
    set_mode(mhp_pkg::MODE_DIRSTB);
    access(1'b1, 7'h15, 8'h3C);
    `CHK("wr addr", 7'h15, last_wa)
    access(1'b0, 7'h00, 8'h00);
    `CHK("rd data", 8'h5A, rsp_rdata)
    $display("test dir done");
  endtask

  task automatic t_mux;
    set_mode(mhp_pkg::MODE_MUX);
    access(1'b1, 7'h2A, 8'hC3);
    `CHK("wr addr", 7'h2A, last_wa)
    `CHK("latched addr", 7'h2A, ale_ad[6:0])
    access(1'b0, 7'h15, 8'h00);
    `CHK("rd data", 8'h3C, rsp_rdata)
    `CHK("rd addr", 7'h15, last_ra)
    $display("test mux done");
  endtask

  task automatic t_eprom;
    set_mode(mhp_pkg::MODE_EPROM);
    access(1'b0, 7'h2A, 8'h00);
    `CHK("rd data", 8'hC3, rsp_rdata)
    `CHK("addr pins", 7'h2A, pin_addr)
    $display("test eprom done");
  endtask

  task automatic t_serial;
    set_mode(mhp_pkg::MODE_SERIAL);
    access(1'b1, 7'h55, 8'h81);
    `CHK("frame", {1'b0, 7'h55, 8'h81}, ser_sh)
    `CHK("wr data", 8'h81, last_wd)
    access(1'b0, 7'h55, 8'h00);
    `CHK("rd header", {1'b1, 7'h55}, ser_sh[15:8])
    `CHK("rd data", 8'h81, rsp_rdata)
    `CHK("rd addr", 7'h55, last_ra)
    $display("test serial done");
  endtask

  // reset lands in mid-frame; the straps must rule again afterwards
  task automatic t_mid_reset;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    // one take only: the request drops at the edge that accepts it
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (39) @(posedge clk);
    `CHK("busy mid frame", 1'b0, cmd_ready)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("cs_n in reset", 1'b1, u_mhp_bus_if.cs_n)
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("mode_sel", 3'h5, mode_sel)
    access(1'b0, 7'h7F, 8'h00);
    `CHK("rd data", 8'hA5, rsp_rdata)
    $display("test mid reset done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_straps();
    t_rwstb();
    t_dir();
    t_mux();
    t_eprom();
    t_serial();
    t_mid_reset();
    close_out();
  end

  // a hang counts against the run and ends it the same way
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
